// [irq_prio_pkg.sv]
// Package for the interrupt priority level register block
`default_nettype none
package irq_prio_pkg;
    // Register indices, one 16-bit register per word
    localparam logic [3:0] IRQ_PRIORITY_REG_0_OFS = 4'h0;
    localparam logic [3:0] IRQ_PRIORITY_REG_1_OFS = 4'h1;
    localparam logic [3:0] IRQ_PRIORITY_REG_2_OFS = 4'h2;
    localparam logic [3:0] IRQ_PRIORITY_REG_3_OFS = 4'h3;
    localparam logic [15:0] PRIO_RESET = 16'h0000;
    // Writable bits of each register
    localparam logic [15:0] REG0_MASK = 16'h3C00;
    localparam logic [15:0] REG1_MASK = 16'h003F;
    localparam logic [15:0] REG2_MASK = 16'hFFCF;
    localparam logic [15:0] REG3_MASK = 16'hFFFC;
    // Field low bit positions
    localparam int BKPT0_POS = 12;
    localparam int STEPCNT_POS = 10;
    localparam int RXFULL_POS = 4;
    localparam int TXEMPTY_POS = 2;
    localparam int TRACE_POS = 0;
    localparam int FL_BE_POS = 14;
    localparam int FL_CC_POS = 12;
    localparam int FL_ERR_POS = 10;
    localparam int PLL_LOCK_POS = 8;
    localparam int LOW_VOLT_POS = 6;
    localparam int PIN_B_POS = 2;
    localparam int PIN_A_POS = 0;
    localparam int PORT_D_POS = 14;
    localparam int PORT_E_POS = 12;
    localparam int PORT_F_POS = 10;
    localparam int CAN_MSG_POS = 8;
    localparam int CAN_WAKE_POS = 6;
    localparam int CAN_ERR_POS = 4;
    localparam int CAN_BOFF_POS = 2;
    // Source counts: debug sources come first in the request vector
    localparam int NUM_DEBUG = 5;
    localparam int NUM_SRC = 19;
    localparam logic [1:0] FIELD_OFF = 2'h0;
endpackage : irq_prio_pkg
`default_nettype wire

// [irq_priority_level_regs.sv]
// Interrupt priority level registers and request level tagging
//
// Overview of operation
// - Reserved bits read zero and ignore writes.
// - Every 2-bit level field resets to 00, meaning source disabled.
// - Debug sources map codes 01,10,11 to levels 1,2,3.
// - Other sources map codes 01,10,11 to levels 0,1,2.
// - Reg 0: breakpoint 0 at 13-12, step counter at 11-10.
// - Reg 1: receive full 5-4, transmit empty 3-2, trace 1-0.
// - Reg 2: flash buffers empty 15-14, complete 13-12, error 11-10.
// - Reg 2: PLL lock 9-8, low voltage 7-6, pin B 3-2, pin A 1-0.
// - Reg 3: ports D, E, F at 15-14, 13-12, 11-10.
// - Reg 3: CAN message buffer 9-8, CAN wake-up 7-6.
// - Reg 3: CAN error 5-4, CAN bus-off 3-2, bits 1-0 reserved.
//
// The strobed register port is this design's own decision.
`default_nettype none
module irq_priority_level_regs
    import irq_prio_pkg::*;
(
    // Clock and reset
    input wire logic mclk_i,
    input wire logic arst_n_i,
    // Register port
    input wire logic [3:0] addr_i,
    input wire logic [15:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [15:0] rdata_o,
    // Requests from sources: 0..4 debug, 5..18 others
    input wire logic [NUM_SRC-1:0] src_req_i,
    // Requests to the core with their level (0..3)
    output logic [NUM_SRC-1:0] core_req_o,
    output logic [NUM_SRC*2-1:0] core_level_o
);

    logic [15:0] reg0_q, reg0_d;
    logic [15:0] reg1_q, reg1_d;
    logic [15:0] reg2_q, reg2_d;
    logic [15:0] reg3_q, reg3_d;
    logic [15:0] rdata_q, rdata_d;
    logic [NUM_SRC-1:0] req_q, req_d;
    logic [NUM_SRC*2-1:0] lvl_q, lvl_d;
    logic [NUM_SRC*2-1:0] fields;

    // Register writes: only writable bits change
    always_comb begin
        reg0_d = reg0_q;
        reg1_d = reg1_q;
        reg2_d = reg2_q;
        reg3_d = reg3_q;
        if (wr_i) begin
            unique case (addr_i)
                IRQ_PRIORITY_REG_0_OFS: reg0_d = wdata_i & REG0_MASK;
                IRQ_PRIORITY_REG_1_OFS: reg1_d = wdata_i & REG1_MASK;
                IRQ_PRIORITY_REG_2_OFS: reg2_d = wdata_i & REG2_MASK;
                IRQ_PRIORITY_REG_3_OFS: reg3_d = wdata_i & REG3_MASK;
                default: ;
            endcase
        end
    end

    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            reg0_q <= PRIO_RESET;
            reg1_q <= PRIO_RESET;
            reg2_q <= PRIO_RESET;
            reg3_q <= PRIO_RESET;
        end else begin
            reg0_q <= reg0_d;
            reg1_q <= reg1_d;
            reg2_q <= reg2_d;
            reg3_q <= reg3_d;
        end
    end

    // Read data, valid the cycle after the read strobe
    always_comb begin
        rdata_d = 16'h0000;
        if (rd_i) begin
            unique case (addr_i)
                IRQ_PRIORITY_REG_0_OFS: rdata_d = reg0_q;
                IRQ_PRIORITY_REG_1_OFS: rdata_d = reg1_q;
                IRQ_PRIORITY_REG_2_OFS: rdata_d = reg2_q;
                IRQ_PRIORITY_REG_3_OFS: rdata_d = reg3_q;
                default: rdata_d = 16'h0000; // Unmapped reads zero
            endcase
        end
    end

    // Field gather, one 2-bit code per source
    always_comb begin
        fields[1:0] = reg0_q[BKPT0_POS +: 2];
        fields[3:2] = reg0_q[STEPCNT_POS +: 2];
        fields[5:4] = reg1_q[RXFULL_POS +: 2];
        fields[7:6] = reg1_q[TXEMPTY_POS +: 2];
        fields[9:8] = reg1_q[TRACE_POS +: 2];
        fields[11:10] = reg2_q[FL_BE_POS +: 2];
        fields[13:12] = reg2_q[FL_CC_POS +: 2];
        fields[15:14] = reg2_q[FL_ERR_POS +: 2];
        fields[17:16] = reg2_q[PLL_LOCK_POS +: 2];
        fields[19:18] = reg2_q[LOW_VOLT_POS +: 2];
        fields[21:20] = reg2_q[PIN_B_POS +: 2];
        fields[23:22] = reg2_q[PIN_A_POS +: 2];
        fields[25:24] = reg3_q[PORT_D_POS +: 2];
        fields[27:26] = reg3_q[PORT_E_POS +: 2];
        fields[29:28] = reg3_q[PORT_F_POS +: 2];
        fields[31:30] = reg3_q[CAN_MSG_POS +: 2];
        fields[33:32] = reg3_q[CAN_WAKE_POS +: 2];
        fields[35:34] = reg3_q[CAN_ERR_POS +: 2];
        fields[37:36] = reg3_q[CAN_BOFF_POS +: 2];
    end

    // Request masking and level decode
    always_comb begin
        for (int i = 0; i < NUM_SRC; i++) begin
            req_d[i] = src_req_i[i] && (fields[2*i +: 2] != FIELD_OFF);
            if (fields[2*i +: 2] == FIELD_OFF) begin
                lvl_d[2*i +: 2] = 2'h0;
            end else if (i < NUM_DEBUG) begin
                lvl_d[2*i +: 2] = fields[2*i +: 2];
            end else begin
                lvl_d[2*i +: 2] = fields[2*i +: 2] - 2'h1;
            end
        end
    end

    // Output registers
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rdata_q <= 16'h0000;
            req_q <= '0;
            lvl_q <= '0;
        end else begin
            rdata_q <= rdata_d;
            req_q <= req_d;
            lvl_q <= lvl_d;
        end
    end

    assign rdata_o = rdata_q;
    assign core_req_o = req_q;
    assign core_level_o = lvl_q;

    // Reserved bits never read back set
    reserved_zero_a: assert property (
        @(posedge mclk_i) disable iff (!arst_n_i)
        (reg0_q & ~REG0_MASK) == 16'h0000 && (reg1_q & ~REG1_MASK) == 16'h0000
        && (reg2_q & ~REG2_MASK) == 16'h0000
        && (reg3_q & ~REG3_MASK) == 16'h0000)
        else $error("reserved bit set");

    // Write reaches register 3 masked
    reg3_write_a: assert property (
        @(posedge mclk_i) disable iff (!arst_n_i)
        wr_i && addr_i == IRQ_PRIORITY_REG_3_OFS
        |=> reg3_q == ($past(wdata_i) & REG3_MASK))
        else $error("register 3 write wrong");

    // Read returns register 1 next cycle
    read_data_a: assert property (
        @(posedge mclk_i) disable iff (!arst_n_i)
        rd_i && addr_i == IRQ_PRIORITY_REG_1_OFS && !wr_i
        |=> rdata_o == $past(reg1_q))
        else $error("read data wrong");

    // Disabled source never reaches core
    mask_off_a: assert property (
        @(posedge mclk_i) disable iff (!arst_n_i)
        reg2_q[PIN_A_POS +: 2] == FIELD_OFF |=> !core_req_o[11])
        else $error("disabled pin A forwarded");

    // Debug breakpoint level equals code
    debug_level_a: assert property (
        @(posedge mclk_i) disable iff (!arst_n_i)
        src_req_i[0] && reg0_q[BKPT0_POS +: 2] != FIELD_OFF
        |=> core_req_o[0] && core_level_o[1:0] == $past(reg0_q[13:12]))
        else $error("debug level wrong");

    // Flash buffers empty level is code minus one
    other_level_a: assert property (
        @(posedge mclk_i) disable iff (!arst_n_i)
        src_req_i[5] && reg2_q[FL_BE_POS +: 2] == 2'h3
        |=> core_req_o[5] && core_level_o[11:10] == 2'h2)
        else $error("non debug level wrong");

    // Port D field sits in bits 15-14
    port_d_map_a: assert property (
        @(posedge mclk_i) disable iff (!arst_n_i)
        src_req_i[12] && reg3_q[15:14] == 2'h1
        |=> core_req_o[12] && core_level_o[25:24] == 2'h0)
        else $error("port D mapping wrong");

    // Step counter field in bits 11-10
    step_map_a: assert property (
        @(posedge mclk_i) disable iff (!arst_n_i)
        src_req_i[1] && reg0_q[11:10] == 2'h2
        |=> core_level_o[3:2] == 2'h2)
        else $error("step counter mapping wrong");

    reg0_write_a: assert property (
        @(posedge mclk_i) disable iff (!arst_n_i)
        wr_i && addr_i == IRQ_PRIORITY_REG_0_OFS
        |=> reg0_q == ($past(wdata_i) & REG0_MASK))
        else $error("register 0 write wrong");

    reg1_write_a: assert property (
        @(posedge mclk_i) disable iff (!arst_n_i)
        wr_i && addr_i == IRQ_PRIORITY_REG_1_OFS
        |=> reg1_q == ($past(wdata_i) & REG1_MASK))
        else $error("register 1 write wrong");

    reg2_write_a: assert property (
        @(posedge mclk_i) disable iff (!arst_n_i)
        wr_i && addr_i == IRQ_PRIORITY_REG_2_OFS
        |=> reg2_q == ($past(wdata_i) & REG2_MASK))
        else $error("register 2 write wrong");

    unmapped_write_a: assert property (
        @(posedge mclk_i) disable iff (!arst_n_i)
        wr_i && addr_i > IRQ_PRIORITY_REG_3_OFS
        |=> $stable(reg0_q) && $stable(reg1_q) && $stable(reg2_q)
        && $stable(reg3_q))
        else $error("unmapped write changed a register");

    // Read strobe aimed past the last register
    sequence unmapped_read_s;
        rd_i && addr_i > IRQ_PRIORITY_REG_3_OFS;
    endsequence

    // Read strobe followed by a quiet cycle
    sequence read_then_idle_s;
        rd_i ##1 !rd_i;
    endsequence

    unmapped_read_a: assert property (
        @(posedge mclk_i) disable iff (!arst_n_i)
        unmapped_read_s |=> rdata_o == 16'h0000)
        else $error("unmapped read not zero");

    // read data stand one cycle only
    read_clear_a: assert property (
        @(posedge mclk_i) disable iff (!arst_n_i)
        read_then_idle_s |=> rdata_o == 16'h0000)
        else $error("read data held too long");

    // receive full field in bits 5-4
    rx_full_map_a: assert property (
        @(posedge mclk_i) disable iff (!arst_n_i)
        src_req_i[2] && reg1_q[5:4] == 2'h1
        |=> core_req_o[2] && core_level_o[5:4] == 2'h1)
        else $error("receive full mapping wrong");

    // trace buffer field in bits 1-0
    trace_map_a: assert property (
        @(posedge mclk_i) disable iff (!arst_n_i)
        src_req_i[4] && reg1_q[1:0] == 2'h3
        |=> core_req_o[4] && core_level_o[9:8] == 2'h3)
        else $error("trace buffer mapping wrong");

    // flash error field in bits 11-10
    flash_err_map_a: assert property (
        @(posedge mclk_i) disable iff (!arst_n_i)
        src_req_i[7] && reg2_q[11:10] == 2'h1
        |=> core_req_o[7] && core_level_o[15:14] == 2'h0)
        else $error("flash error mapping wrong");

    // low voltage field in bits 7-6
    low_volt_map_a: assert property (
        @(posedge mclk_i) disable iff (!arst_n_i)
        src_req_i[9] && reg2_q[7:6] == 2'h2
        |=> core_req_o[9] && core_level_o[19:18] == 2'h1)
        else $error("low voltage mapping wrong");

    // CAN wake-up field in bits 7-6
    can_wake_map_a: assert property (
        @(posedge mclk_i) disable iff (!arst_n_i)
        src_req_i[16] && reg3_q[7:6] == 2'h3
        |=> core_req_o[16] && core_level_o[33:32] == 2'h2)
        else $error("CAN wake-up mapping wrong");

    // CAN bus-off field in bits 3-2
    bus_off_map_a: assert property (
        @(posedge mclk_i) disable iff (!arst_n_i)
        src_req_i[18] && reg3_q[3:2] == 2'h2
        |=> core_req_o[18] && core_level_o[37:36] == 2'h1)
        else $error("CAN bus-off mapping wrong");

    // disabled field gives no request and level zero
    off_level_zero_a: assert property (
        @(posedge mclk_i) disable iff (!arst_n_i)
        reg0_q[13:12] == 2'h0
        |=> !core_req_o[0] && core_level_o[1:0] == 2'h0)
        else $error("disabled breakpoint source active");

    idle_source_a: assert property (
        @(posedge mclk_i) disable iff (!arst_n_i)
        !src_req_i[9] |=> !core_req_o[9])
        else $error("idle low voltage source forwarded");

endmodule : irq_priority_level_regs
`default_nettype wire

// [irq_priority_level_regs_tb.sv]
// Testbench for the priority level register block
`default_nettype none
module irq_priority_level_regs_tb
    import irq_prio_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int RG[NUM_SRC] = '{0,0,1,1,1,2,2,2,2,2,2,2,3,3,3,3,3,3,3};
    localparam int PS[NUM_SRC] = '{12,10,4,2,0,14,12,10,8,6,2,0,
                                   14,12,10,8,6,4,2};
    localparam logic [15:0] MSK[4] = '{16'h3C00, 16'h003F, 16'hFFCF,
                                       16'hFFFC};
    logic mclk_i = 1'b0;
    logic arst_n_i = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [15:0] wdata = 16'h0000;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [15:0] rdata;
    logic [15:0] rv;
    logic [NUM_SRC-1:0] pattern = '0;
    logic [NUM_SRC-1:0] src_req;
    logic [NUM_SRC-1:0] core_req;
    logic [NUM_SRC*2-1:0] core_level;
    logic [NUM_SRC*2-1:0] lv;
    int n_fail = 0;
    int check_count = 0;

    irq_source_model src (.mclk_i(mclk_i), .arst_n_i(arst_n_i),
        .pattern_i(pattern), .src_req_o(src_req));
    irq_priority_level_regs dut (.mclk_i(mclk_i), .arst_n_i(arst_n_i),
        .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
        .rdata_o(rdata), .src_req_i(src_req), .core_req_o(core_req),
        .core_level_o(core_level));

    // Free running system clock
    always #10 mclk_i = ~mclk_i;

    task automatic chk(input logic [NUM_SRC*2-1:0] got,
                       input logic [NUM_SRC*2-1:0] exp);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: got %h, expected %h", $time, got,
                     exp);
        end
    endtask : chk

    task automatic put(input int a, input logic [15:0] d);
        @(posedge mclk_i);
        addr <= a[3:0];
        wdata <= d;
        wr <= 1'b1;
        @(posedge mclk_i);
        wr <= 1'b0;
    endtask : put

    // Read data stand only in the cycle after the strobe
    task automatic get(input int a, output logic [15:0] d);
        @(posedge mclk_i);
        addr <= a[3:0];
        rd <= 1'b1;
        @(posedge mclk_i);
        rd <= 1'b0;
        #1 d = rdata;
    endtask : get

    // Two register stages between pattern and core outputs
    task automatic settle();
        repeat (3) @(posedge mclk_i);
        #1;
    endtask : settle

    task automatic stop_test();
        $display("checks %0d, mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : stop_test

    // Cuts a hang short
    initial begin
        repeat (5000) @(posedge mclk_i);
        n_fail++;
        stop_test();
    end

    initial begin
        repeat (10) @(posedge mclk_i);
        arst_n_i <= 1'b1;
        pattern <= '1;
        settle();
        chk(core_req, '0);
        for (int r = 0; r < 6; r++) begin
            get(r, rv);
            chk(rv, '0);
            put(r, 16'hFFFF);
            get(r, rv);
            chk(rv, (r < 4) ? MSK[r] : 16'h0000);
            @(posedge mclk_i);
            #1 chk(rdata, 16'h0000);
        end
        for (int c = 1; c < 4; c++) begin
            for (int r = 0; r < 4; r++) put(r, {8{c[1:0]}});
            settle();
            for (int i = 0; i < NUM_SRC; i++)
                lv[2*i+:2] = (i < NUM_DEBUG) ? c[1:0] : c[1:0] - 2'h1;
            chk(core_req, {NUM_SRC{1'b1}});
            chk(core_level, lv);
        end
        for (int r = 0; r < 4; r++) put(r, 16'h0000);
        for (int i = 0; i < NUM_SRC; i++) begin
            put(RG[i], 16'h2 << PS[i]);
            get(RG[i], rv);
            chk(rv, 16'h2 << PS[i]);
            settle();
            lv = '0;
            lv[2*i+:2] = (i < NUM_DEBUG) ? 2'h2 : 2'h1;
            chk(core_req, 38'h1 << i);
            chk(core_level, lv);
            put(RG[i], 16'h0000);
        end
        put(3, 16'h000C);
        get(3, rv);
        chk(rv, 16'h000C);
        pattern <= '0;
        settle();
        chk(core_req, '0);
        pattern <= '1;
        settle();
        chk(core_req, 38'h1 << 18);
        chk(core_level, 38'h2 << 36);
        // Second reset in mid run clears every field
        arst_n_i <= 1'b0;
        repeat (2) @(posedge mclk_i);
        arst_n_i <= 1'b1;
        settle();
        chk(core_req, '0);
        get(3, rv);
        chk(rv, 16'h0000);
        stop_test();
    end
endmodule : irq_priority_level_regs_tb
`default_nettype wire

// [irq_source_model.sv]
// Model of the peripheral request lines feeding the block
`default_nettype none
module irq_source_model
    import irq_prio_pkg::*;
(
    // Clock and reset
    input wire logic mclk_i,
    input wire logic arst_n_i,
    // Pattern asked for by the bench
    input wire logic [NUM_SRC-1:0] pattern_i,
    // Level requests toward the block
    output logic [NUM_SRC-1:0] src_req_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [NUM_SRC-1:0] req_q;
    // Flags launch on the rising edge, as real peripherals do
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            req_q <= '0;
        end else begin
            req_q <= pattern_i;
        end
    end
    assign src_req_o = req_q;
endmodule : irq_source_model
`default_nettype wire
